// ==== rtl/nfcp_map.vh ====
// constants for the flash channel port: command codes and strobe timing
`ifndef NFCP_MAP_VH
`define NFCP_MAP_VH

// ************************************************************
// command codes on the user command port
// ************************************************************
`define NFCP_TYPE_CMD 2'h0
`define NFCP_TYPE_ADDR 2'h1
`define NFCP_TYPE_WDATA 2'h2
`define NFCP_TYPE_READ 2'h3

// ************************************************************
// geometry
// ************************************************************
`define NFCP_CHANNELS 8
`define NFCP_BANKS 16
`define NFCP_BANK_BITS 4
`define NFCP_SYNC_STAGES 2

// ************************************************************
// timing, in ns, and derived cycle counts (least times round up)
// ************************************************************
`define NFCP_CLK_NS 8
`define NFCP_T_WE_LOW_NS 25
`define NFCP_T_WE_HIGH_NS 15
`define NFCP_T_READ_ACCESS_NS 20
`define NFCP_T_RE_HIGH_NS 15
`define NFCP_WE_LOW_CYC ((`NFCP_T_WE_LOW_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)
`define NFCP_WE_HIGH_CYC ((`NFCP_T_WE_HIGH_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)
`define NFCP_READ_ACCESS_CYC ((`NFCP_T_READ_ACCESS_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)
`define NFCP_RE_HIGH_CYC ((`NFCP_T_RE_HIGH_NS + `NFCP_CLK_NS - 1) / `NFCP_CLK_NS)

`endif

// ==== rtl/nfcp_sync.v ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module nfcp_sync #(
	parameter WIDTH = 8
) (
	input wire clk, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire [WIDTH-1:0] d, // asynchronous input
	output wire [WIDTH-1:0] q // synchronised output
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// meta_reg is read by sync_reg only
	always @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;

endmodule // nfcp_sync

// ==== rtl/nfcp_buf2.v ====
// two-entry valid/ready buffer for captured read bytes
`timescale 1ns/1ps

module nfcp_buf2 #(
	parameter WIDTH = 8
) (
	input wire clk, // system clock
	input wire rst_n, // synchronous reset, active low
	input wire in_valid, // push request
	output wire in_ready, // not full
	input wire [WIDTH-1:0] in_data, // pushed word
	output wire out_valid, // not empty
	input wire out_ready, // pop request
	output wire [WIDTH-1:0] out_data // head word
);

	reg [WIDTH-1:0] mem_reg [0:1];
	reg wr_ptr_reg;
	reg rd_ptr_reg;
	reg [1:0] count_reg;
	wire push;
	wire pop;

	assign push = in_valid && (count_reg != 2'h2);
	assign pop = out_ready && (count_reg != 2'h0);
	assign in_ready = (count_reg != 2'h2);
	assign out_valid = (count_reg != 2'h0);
	assign out_data = mem_reg[rd_ptr_reg];

	always @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
			end
		end
	end

endmodule // nfcp_buf2

// ==== rtl/nfcp_top.v ====
// eight-channel raw flash port: command, address, write and read byte sequencers
`timescale 1ns/1ps
`include "nfcp_map.vh"

// Functional notes
// R01 - eight channels, each with an 8-bit two-way data bus
// R02 - each channel drives its own active-low write strobe
// R03 - byte on the bus stays stable across the write strobe rising edge
// R04 - address cycles hold address latch enable high through the write strobe
// R05 - address latch enable opens the path to flash address registers
// R06 - command cycles hold command latch enable high through the write strobe
// R07 - flash drives the bus while the read strobe is low
// R08 - read data sampled no earlier than the read access delay after strobe falls
// R09 - sixteen active-low bank selects, one per flash target
// R10 - busy flash ignores its bank select going high
// R11 - global reset low resets every sequencer and its strobes
// R12 - never both latch enables together; both low while idle
module nfcp_top #(
	parameter WE_LOW_CYC = `NFCP_WE_LOW_CYC,
	parameter WE_HIGH_CYC = `NFCP_WE_HIGH_CYC,
	parameter READ_ACCESS_CYC = `NFCP_READ_ACCESS_CYC,
	parameter RE_HIGH_CYC = `NFCP_RE_HIGH_CYC
) (
	input wire CLOCK, // system clock, 125 MHz
	input wire RESET_N, // global reset, synchronous, active low
	input wire [7:0] CMD_VALID, // per channel: request present
	output wire [7:0] CMD_READY, // per channel: request taken when valid
	input wire [15:0] CMD_TYPE, // per channel 2 bits: cmd, addr, write data, read
	input wire [63:0] CMD_DATA, // per channel byte to write
	input wire [31:0] CMD_BANK, // per channel 4-bit target bank
	output wire [7:0] RD_VALID, // per channel: read byte available
	input wire [7:0] RD_READY, // per channel: read byte consumed
	output wire [63:0] RD_DATA, // per channel read byte
	input wire [63:0] FL_DQ_IN, // flash data bus, pad input
	output wire [63:0] FL_DQ_OUT, // flash data bus, pad output
	output wire [7:0] FL_DQ_OE, // flash data bus drive enable, high drives
	output wire [7:0] FL_WE_N, // write strobe, active low
	output wire [7:0] FL_RE_N, // read strobe, active low
	output wire [7:0] FL_ALE, // address latch enable
	output wire [7:0] FL_CLE, // command latch enable
	output wire [15:0] BANK_SELECT_N // bank selects, active low
);

	// ************************************************************
	// states and helpers
	// ************************************************************
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_SETUP = 6'h02;
	localparam [5:0] S_WLOW = 6'h04;
	localparam [5:0] S_WHIGH = 6'h08;
	localparam [5:0] S_RLOW = 6'h10;
	localparam [5:0] S_RHIGH = 6'h20;

	localparam [3:0] WE_LOW_LOAD = WE_LOW_CYC[3:0] - 4'h1;
	localparam [3:0] WE_HIGH_LOAD = WE_HIGH_CYC[3:0] - 4'h1;
	// sampling waits out the access delay plus the pad synchroniser
	localparam [3:0] READ_LOAD = READ_ACCESS_CYC[3:0] + 4'h1;
	localparam [3:0] RE_HIGH_LOAD = RE_HIGH_CYC[3:0] - 4'h1;

	function [15:0] bank_decode;
		input [3:0] bank;
		begin
			bank_decode = 16'h0001 << bank;
		end
	endfunction

	wire [15:0] chan_active;
	wire [63:0] chan_bank;
	reg [15:0] bank_sel_n_reg;

	// ************************************************************
	// per-channel sequencers
	// ************************************************************
	genvar i;
	generate
		for (i = 0; i < `NFCP_CHANNELS; i = i + 1) begin : g_chan // R01
			reg [5:0] state_reg;
			reg [3:0] cnt_reg;
			reg cmd_ready_reg;
			reg [1:0] type_reg;
			reg [7:0] dq_out_reg;
			reg dq_oe_reg;
			reg we_n_reg;
			reg re_n_reg;
			reg ale_reg;
			reg cle_reg;
			reg active_reg;
			reg [3:0] bank_reg;
			wire [7:0] dq_sync;
			wire buf_in_ready;
			wire push;
			wire accept;
			wire [1:0] req_type;

			assign req_type = CMD_TYPE[2*i+1:2*i];
			assign accept = CMD_VALID[i] && cmd_ready_reg;
			assign push = state_reg[4] && (cnt_reg == 4'h0);

			nfcp_sync #(
				.WIDTH(8)
			) u_sync (
				.clk(CLOCK),
				.rst_n(RESET_N),
				.d(FL_DQ_IN[8*i+7:8*i]),
				.q(dq_sync)
			);

			// the buffer absorbs a stall on the read side; a read is only taken when it
			// has room, so a captured byte never has to wait
			nfcp_buf2 #(
				.WIDTH(8)
			) u_buf (
				.clk(CLOCK),
				.rst_n(RESET_N),
				.in_valid(push),
				.in_ready(buf_in_ready),
				.in_data(dq_sync),
				.out_valid(RD_VALID[i]),
				.out_ready(RD_READY[i]),
				.out_data(RD_DATA[8*i+7:8*i])
			);

			always @(posedge CLOCK) begin
				if (!RESET_N) begin // R11
					state_reg <= S_IDLE;
					cnt_reg <= 4'h0;
					cmd_ready_reg <= 1'b0;
					type_reg <= `NFCP_TYPE_CMD;
					dq_out_reg <= 8'h00;
					dq_oe_reg <= 1'b0;
					we_n_reg <= 1'b1;
					re_n_reg <= 1'b1;
					ale_reg <= 1'b0;
					cle_reg <= 1'b0;
					active_reg <= 1'b0;
					bank_reg <= 4'h0;
				end else begin
					case (state_reg)
						S_IDLE: begin
							// idle readiness also needs buffer room; room can only grow here
							cmd_ready_reg <= buf_in_ready;
							if (accept) begin
								cmd_ready_reg <= 1'b0;
								type_reg <= req_type;
								bank_reg <= CMD_BANK[4*i+3:4*i];
								active_reg <= 1'b1;
								state_reg <= S_SETUP;
								if (req_type == `NFCP_TYPE_READ) begin
									dq_oe_reg <= 1'b0; // R07
								end else begin
									dq_out_reg <= CMD_DATA[8*i+7:8*i];
									dq_oe_reg <= 1'b1;
								end
								ale_reg <= (req_type == `NFCP_TYPE_ADDR); // R05 R12
								cle_reg <= (req_type == `NFCP_TYPE_CMD); // R06 R12
							end
						end
						S_SETUP: begin
							// one cycle lets the latch enables settle first; the bank select falls on the same edge as the strobe
							if (type_reg == `NFCP_TYPE_READ) begin
								re_n_reg <= 1'b0; // R07
								cnt_reg <= READ_LOAD;
								state_reg <= S_RLOW;
							end else begin
								we_n_reg <= 1'b0; // R02
								cnt_reg <= WE_LOW_LOAD;
								state_reg <= S_WLOW;
							end
						end
						S_WLOW: begin
							if (cnt_reg == 4'h0) begin
								we_n_reg <= 1'b1; // R02
								cnt_reg <= WE_HIGH_LOAD;
								state_reg <= S_WHIGH;
							end else begin
								cnt_reg <= cnt_reg - 4'h1;
							end
						end
						S_WHIGH: begin
							// byte and latch enables held after the rising edge
							if (cnt_reg == 4'h0) begin // R03 R04 R06
								dq_oe_reg <= 1'b0;
								ale_reg <= 1'b0; // R12
								cle_reg <= 1'b0; // R12
								active_reg <= 1'b0;
								state_reg <= S_IDLE;
							end else begin
								cnt_reg <= cnt_reg - 4'h1;
							end
						end
						S_RLOW: begin
							if (cnt_reg == 4'h0) begin // R08
								re_n_reg <= 1'b1;
								cnt_reg <= RE_HIGH_LOAD;
								state_reg <= S_RHIGH;
							end else begin
								cnt_reg <= cnt_reg - 4'h1;
							end
						end
						S_RHIGH: begin
							if (cnt_reg == 4'h0) begin
								active_reg <= 1'b0;
								state_reg <= S_IDLE;
							end else begin
								cnt_reg <= cnt_reg - 4'h1;
							end
						end
						default: begin
							state_reg <= S_IDLE;
							we_n_reg <= 1'b1;
							re_n_reg <= 1'b1;
							ale_reg <= 1'b0;
							cle_reg <= 1'b0;
							dq_oe_reg <= 1'b0;
							active_reg <= 1'b0;
						end
					endcase
				end
			end

			assign CMD_READY[i] = cmd_ready_reg;
			assign FL_DQ_OUT[8*i+7:8*i] = dq_out_reg;
			assign FL_DQ_OE[i] = dq_oe_reg;
			assign FL_WE_N[i] = we_n_reg;
			assign FL_RE_N[i] = re_n_reg;
			assign FL_ALE[i] = ale_reg;
			assign FL_CLE[i] = cle_reg;
			assign chan_active[i] = active_reg;
			assign chan_bank[4*i+3:4*i] = bank_reg;
		end
		for (i = `NFCP_CHANNELS; i < 16; i = i + 1) begin : g_pad
			assign chan_active[i] = 1'b0;
			assign chan_bank[4*i+3:4*i] = 4'h0;
		end
	endgenerate

	// ************************************************************
	// bank selects
	// ************************************************************
	// a bank is selected while any channel works on it; two channels aimed at one
	// bank are not arbitrated here, the firmware must keep them apart
	reg [15:0] sel_any;
	integer k;
	always @* begin
		sel_any = 16'h0000;
		for (k = 0; k < `NFCP_CHANNELS; k = k + 1) begin
			if (chan_active[k]) begin
				sel_any = sel_any | bank_decode(chan_bank[4*k+:4]);
			end
		end
	end

	always @(posedge CLOCK) begin
		if (!RESET_N) begin // R11
			bank_sel_n_reg <= 16'hffff;
		end else begin
			bank_sel_n_reg <= ~sel_any; // R09
		end
	end

	// a busy target ignores the select going high, so release after a
	// program byte is safe without waiting for the operation to end
	assign BANK_SELECT_N = bank_sel_n_reg; // R10

endmodule // nfcp_top

// ==== test/nfcp_chk.sv ====
// checker for the flash channel port, bound to its top module
`timescale 1ns/1ps

module nfcp_chk #(
	parameter int WE_LOW_CYC = 4
) (
	input wire CLOCK, // system clock
	input wire RESET_N, // synchronous reset, active low
	input wire [7:0] CMD_VALID, // request present
	input wire [7:0] CMD_READY, // request taken
	input wire [7:0] RD_VALID, // read byte available
	input wire [7:0] RD_READY, // read byte consumed
	input wire [63:0] RD_DATA, // read bytes
	input wire [63:0] FL_DQ_OUT, // bytes driven out
	input wire [7:0] FL_DQ_OE, // bus drive enables
	input wire [7:0] FL_WE_N, // write strobes
	input wire [7:0] FL_RE_N, // read strobes
	input wire [7:0] FL_ALE, // address latch enables
	input wire [7:0] FL_CLE, // command latch enables
	input wire [15:0] BANK_SELECT_N // bank selects
);
	// ************************************************************
	// strobe and handshake properties
	// ************************************************************
	localparam int WL1 = WE_LOW_CYC - 1;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RESET_N);

	latch_excl_a: assert property ((FL_ALE & FL_CLE) == 8'h00)
		else $error("both latch enables high");
	idle_quiet_a: assert property (CMD_READY[0] |-> FL_WE_N[0] && FL_RE_N[0] && !FL_ALE[0] && !FL_CLE[0])
		else $error("strobe active while idle");
	byte_stable_a: assert property ($rose(FL_WE_N[0]) |-> FL_DQ_OE[0] && $stable(FL_DQ_OUT[7:0]))
		else $error("byte moved at write strobe rise");
	we_width_a: assert property ($fell(FL_WE_N[0]) |-> ##WL1 !FL_WE_N[0] ##1 FL_WE_N[0])
		else $error("write strobe width wrong");
	ale_hold_a: assert property (FL_ALE[0] && !FL_WE_N[0] |=> FL_ALE[0] && FL_DQ_OE[0])
		else $error("address latch enable dropped early");
	cle_hold_a: assert property (FL_CLE[2] && !FL_WE_N[2] |=> FL_CLE[2])
		else $error("command latch enable dropped early");
	ready_drop_a: assert property (CMD_VALID[0] && CMD_READY[0] |=> !CMD_READY[0] [*8])
		else $error("ready back too soon");
	bank_busy_a: assert property ((~FL_WE_N | ~FL_RE_N) != 8'h00 |-> BANK_SELECT_N != 16'hffff)
		else $error("strobe without bank select");
	read_bus_a: assert property (!FL_RE_N[7] |-> !FL_DQ_OE[7])
		else $error("bus driven during read");
	re_width_a: assert property ($fell(FL_RE_N[7]) |-> !FL_RE_N[7] [*5] ##1 FL_RE_N[7])
		else $error("read strobe width wrong");
	rd_hold_a: assert property (RD_VALID[7] && !RD_READY[7] |=> RD_VALID[7] && $stable(RD_DATA[63:56]))
		else $error("stalled read byte lost");
	reset_idle_a: assert property ($rose(RESET_N) |-> FL_WE_N == 8'hff && BANK_SELECT_N == 16'hffff)
		else $error("strobes active after reset");

	cover property (FL_ALE[0] && !FL_WE_N[0]);
	cover property (!FL_RE_N[7]);
	cover property (RD_VALID[7] && !CMD_READY[7] && FL_RE_N[7]);
endmodule // nfcp_chk

// ==== test/nfcp_flash.sv ====
// behavioural flash dies, one per channel bus
`timescale 1ns/1ps

module nfcp_flash (
	input wire [63:0] dq_out, // bytes driven by the port
	input wire [7:0] we_n, // write strobes
	input wire [7:0] re_n, // read strobes
	input wire [7:0] ale, // address latch enables
	input wire [7:0] cle, // command latch enables
	output wire [63:0] dq_in, // bytes driven back
	output logic [63:0] cap_cmd, // last command per channel
	output logic [63:0] cap_addr, // last address per channel
	output logic [63:0] cap_data // last write byte per channel
);
	// ************************************************************
	// per channel die
	// ************************************************************
	// no busy phase is modelled, so a select released after a byte is harmless here
	for (genvar g = 0; g < 8; g++) begin : ch
		logic [7:0] col_reg = 8'h00;
		logic [7:0] out_reg = 8'h00;
		always @(posedge we_n[g]) begin
			if (cle[g]) cap_cmd[8*g+:8] = dq_out[8*g+:8];
			else if (ale[g]) begin
				cap_addr[8*g+:8] = dq_out[8*g+:8];
				col_reg = 8'h00;
			end else cap_data[8*g+:8] = dq_out[8*g+:8];
		end
		always @(negedge re_n[g]) begin
			out_reg = cap_addr[8*g+:8] + col_reg;
			col_reg = col_reg + 8'h01;
		end
		// released bus shows the inverse, so a late sample cannot match by luck
		assign dq_in[8*g+:8] = re_n[g] ? ~out_reg : out_reg;
	end
endmodule // nfcp_flash

// ==== test/tb_nand_flash_channel_port.sv ====
// self-checking bench for the flash channel port
`timescale 1ns/1ps
`include "nfcp_map.vh"

module tb_nand_flash_channel_port;
	logic CLOCK = 1'b0;
	logic RESET_N = 1'b0;
	logic [7:0] CMD_VALID = 8'h00;
	logic [15:0] CMD_TYPE = 16'h0000;
	logic [63:0] CMD_DATA = 64'h0;
	logic [31:0] CMD_BANK = 32'h0;
	logic [7:0] RD_READY = 8'h00;
	wire [7:0] CMD_READY, RD_VALID, FL_DQ_OE, FL_WE_N, FL_RE_N, FL_ALE, FL_CLE;
	wire [63:0] RD_DATA, FL_DQ_IN, FL_DQ_OUT, cap_cmd, cap_addr, cap_data;
	wire [15:0] BANK_SELECT_N;
	integer failures = 0;
	integer tests_run = 0;

	always #4 CLOCK = ~CLOCK;

	nfcp_top dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .CMD_VALID(CMD_VALID),
		.CMD_READY(CMD_READY), .CMD_TYPE(CMD_TYPE), .CMD_DATA(CMD_DATA), .CMD_BANK(CMD_BANK),
		.RD_VALID(RD_VALID), .RD_READY(RD_READY), .RD_DATA(RD_DATA), .FL_DQ_IN(FL_DQ_IN),
		.FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_WE_N(FL_WE_N), .FL_RE_N(FL_RE_N),
		.FL_ALE(FL_ALE), .FL_CLE(FL_CLE), .BANK_SELECT_N(BANK_SELECT_N));
	nfcp_flash flash (.dq_out(FL_DQ_OUT), .we_n(FL_WE_N), .re_n(FL_RE_N), .ale(FL_ALE),
		.cle(FL_CLE), .dq_in(FL_DQ_IN), .cap_cmd(cap_cmd), .cap_addr(cap_addr),
		.cap_data(cap_data));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic complete_run;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		tests_run = tests_run + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// bounded wait for the channel to report idle
	task automatic settle(input int ch);
		int n;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
		end while (CMD_READY[ch] !== 1'b1 && n < 40);
		check("ready", 64'h1, CMD_READY[ch]);
		if (CMD_READY[ch] !== 1'b1) complete_run;
	endtask

	task automatic issue(input int ch, input logic [1:0] kind, input logic [7:0] b,
		input logic [3:0] bank);
		@(posedge CLOCK);
		CMD_TYPE[2*ch+:2] <= kind;
		CMD_DATA[8*ch+:8] <= b;
		CMD_BANK[4*ch+:4] <= bank;
		CMD_VALID[ch] <= 1'b1;
		settle(ch);
		CMD_VALID[ch] <= 1'b0;
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic test_write;
		logic [1:0] kind;
		logic [7:0] b;
		for (int ch = 0; ch < 8; ch++) begin
			kind = 2'((ch + 1) % 3);
			b = 8'h31 + 8'(ch * 17);
			issue(ch, kind, b, 4'(2 * ch + 1));
			repeat (3) @(posedge CLOCK);
			check("we", 64'h0, FL_WE_N[ch]);
			check("bank", 16'(~(16'h1 << (2 * ch + 1))), BANK_SELECT_N);
			check("latch", {kind == `NFCP_TYPE_CMD, kind == `NFCP_TYPE_ADDR}, {FL_CLE[ch], FL_ALE[ch]});
			check("out", {1'b1, b}, {FL_DQ_OE[ch], FL_DQ_OUT[8*ch+:8]});
			settle(ch);
			check("seen", b, kind == `NFCP_TYPE_CMD ? cap_cmd[8*ch+:8] : kind == `NFCP_TYPE_ADDR ?
				cap_addr[8*ch+:8] : cap_data[8*ch+:8]);
		end
		$display("test_write done");
	endtask

	// two reads fill the buffer while the consumer stalls
	task automatic test_read;
		issue(7, `NFCP_TYPE_ADDR, 8'h40, 4'hf);
		issue(7, `NFCP_TYPE_READ, 8'h00, 4'hf);
		settle(7);
		issue(7, `NFCP_TYPE_READ, 8'h00, 4'hf);
		repeat (12) @(posedge CLOCK);
		check("full", 64'h0, CMD_READY[7]);
		check("head", 8'h40, RD_DATA[63:56]);
		RD_READY[7] <= 1'b1;
		@(posedge CLOCK);
		check("pop0", {1'b1, 8'h40}, {RD_VALID[7], RD_DATA[63:56]});
		@(posedge CLOCK);
		check("pop1", {1'b1, 8'h41}, {RD_VALID[7], RD_DATA[63:56]});
		RD_READY[7] <= 1'b0;
		@(posedge CLOCK);
		check("empty", 64'h0, RD_VALID[7]);
		issue(7, `NFCP_TYPE_READ, 8'h00, 4'hf);
		settle(7);
		check("pop2", {1'b1, 8'h42}, {RD_VALID[7], RD_DATA[63:56]});
		RD_READY[7] <= 1'b1;
		@(posedge CLOCK);
		RD_READY[7] <= 1'b0;
		$display("test_read done");
	endtask

	task automatic test_reset;
		issue(1, `NFCP_TYPE_WDATA, 8'h5a, 4'h3);
		repeat (3) @(posedge CLOCK);
		RESET_N <= 1'b0;
		repeat (2) @(posedge CLOCK);
		check("idle", {8'hff, 8'hff, 16'hffff, 8'h00, 8'h00, 8'h00},
			{FL_WE_N, FL_RE_N, BANK_SELECT_N, FL_ALE | FL_CLE, FL_DQ_OE, CMD_READY});
		RESET_N <= 1'b1;
		settle(1);
		$display("test_reset done");
	endtask

	initial begin
		repeat (2) @(posedge CLOCK);
		RESET_N <= 1'b1;
		@(posedge CLOCK);
		test_write;
		test_read;
		test_reset;
		complete_run;
	end
endmodule // tb_nand_flash_channel_port

bind nfcp_top nfcp_chk #(.WE_LOW_CYC(WE_LOW_CYC)) chk (.CLOCK(CLOCK), .RESET_N(RESET_N),
	.CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
	.RD_DATA(RD_DATA), .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE), .FL_WE_N(FL_WE_N),
	.FL_RE_N(FL_RE_N), .FL_ALE(FL_ALE), .FL_CLE(FL_CLE), .BANK_SELECT_N(BANK_SELECT_N));
